// File: verilog/mpt_defs.svh
// Offsets, field positions, reset values and timing counts of the PWM time base block
`ifndef MPT_DEFS_SVH
`define MPT_DEFS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define MPT_OFS_TCON 8'h00
`define MPT_OFS_TMR 8'h04
`define MPT_OFS_TPER 8'h08
`define MPT_OFS_SECMP 8'h0C
`define MPT_OFS_CON1 8'h10
`define MPT_OFS_CON2 8'h14
`define MPT_OFS_DTCON1 8'h18
`define MPT_OFS_DTCON2 8'h1C
`define MPT_OFS_DUTY 8'h20
`define MPT_OFS_IRQ_STAT 8'h24
`define MPT_OFS_IRQ_MASK 8'h28

// ----------------------------------------
// Field positions
// ----------------------------------------
`define MPT_TCON_ON 15
`define MPT_TCON_SIDL 13
`define MPT_TCON_OPS_LO 4
`define MPT_TCON_CKPS_LO 2
`define MPT_TCON_MOD_LO 0
`define MPT_TMR_DIR 15
`define MPT_SECMP_DIR 15
`define MPT_CON1_PAIR_MODE 8
`define MPT_CON1_PENH 4
`define MPT_CON1_PENL 0
`define MPT_CON2_SEVOPS_LO 8
`define MPT_DT_B_LO 8
`define MPT_DT_BPS_LO 14
`define MPT_DT_A_LO 0
`define MPT_DT_APS_LO 6
`define MPT_DTS_A 1
`define MPT_DTS_I 0

// ----------------------------------------
// Interrupt status bits
// ----------------------------------------
`define MPT_IRQ_PERIOD 0
`define MPT_IRQ_SEVT 1
`define MPT_IRQ_WIDTH 2

// ----------------------------------------
// Reset values and pin enable settle count
// ----------------------------------------
`define MPT_RST_HALF 16'h0000
`define MPT_RST_MASK 2'h0
`define MPT_PEN_SETTLE 2'h3

`endif

// File: verilog/mpt_pkg.sv
// Types shared by the PWM time base block
package mpt_pkg;
  typedef enum logic [1:0] {
    MPT_FREE_RUN,
    MPT_SINGLE,
    MPT_UPDOWN,
    MPT_UPDOWN_DBL
  } mpt_mode_type;
endpackage

// File: verilog/mpt_prescaler.sv
// Cycle divider giving a one-cycle enable every 1, 4, 16 or 64 ticks, or every 1, 2, 4 or 8 ticks with width_sel[2] set
`timescale 1ns/1ps
`include "mpt_defs.svh"
module mpt_prescaler
  import mpt_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic run,
  input wire logic [1:0] sel,
  input wire logic [2:0] width_sel,
  // Enable out
  output logic tick
);
  logic [5:0] cnt_ff;
  logic [5:0] lim;

  // Terminal count from selection, width_sel picks 2-bit or log scale
  always_comb begin
    if (width_sel[2]) begin
      lim = (6'h01 << sel) - 6'h01;
    end else begin
      case (sel)
        2'h0: lim = 6'h00;
        2'h1: lim = 6'h03;
        2'h2: lim = 6'h0F;
        default: lim = 6'h3F;
      endcase
    end
  end

  // Free counter, restarts when held
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 6'h00;
    end else if (!run) begin
      cnt_ff <= 6'h00;
    end else if (cnt_ff >= lim) begin
      cnt_ff <= 6'h00;
    end else begin
      cnt_ff <= cnt_ff + 6'h01;
    end
  end

  assign tick = run && (cnt_ff >= lim);
endmodule

// File: verilog/mpt_dead_time.sv
// Dead-time insertion on one complementary pair
`timescale 1ns/1ps
`include "mpt_defs.svh"
module mpt_dead_time
  import mpt_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Settings
  input wire logic [5:0] cnt_a,
  input wire logic [1:0] ps_a,
  input wire logic [5:0] cnt_b,
  input wire logic [1:0] ps_b,
  input wire logic sel_act,
  input wire logic sel_inact,
  // Raw high drive
  input wire logic raw_h,
  // Delayed drives
  output logic out_h,
  output logic out_l
);
  logic prev_ff;
  logic [5:0] rem_ff;
  logic busy;
  logic tick;
  logic use_b;
  logic use_b_ff;

  // Unit for the pending edge: active-going or inactive-going
  assign use_b = raw_h ? sel_act : sel_inact;
  assign busy = (rem_ff != 6'h00);

  mpt_prescaler u_ps (
    .clk(clk),
    .rst_n(rst_n),
    .run(busy),
    .sel(use_b_ff ? ps_b : ps_a),
    .width_sel(3'h4),
    .tick(tick)
  );

  // Load dead time on every edge, count down in prescaled steps
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_ff <= 1'b0;
      rem_ff <= 6'h00;
      use_b_ff <= 1'b0;
    end else if (raw_h != prev_ff) begin
      prev_ff <= raw_h;
      rem_ff <= use_b ? cnt_b : cnt_a;
      use_b_ff <= use_b;
    end else if (busy && tick) begin
      rem_ff <= rem_ff - 6'h01;
    end
  end

  // Both sides off while dead time runs, then low inverts high
  always_comb begin
    out_h = prev_ff && !busy;
    out_l = !prev_ff && !busy;
  end
endmodule

// File: verilog/mpt_core.sv
// PWM time base, special event trigger and one output pair behind AHB-Lite
//
// Implementation choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`include "mpt_defs.svh"
module mpt_core
  import mpt_pkg::*;
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESETN,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // System state
  input wire logic CPU_IDLE,
  input wire logic PIN_ENABLE_RESET_CONFIG,
  // Power stage pair
  output logic PWM_H,
  output logic PWM_L,
  output logic PWM_H_OE,
  output logic PWM_L_OE,
  // Events
  output logic SPECIAL_EVENT,
  output logic IRQ
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic time_base_on_ff;
  logic time_base_idle_stop_ff;
  logic [3:0] period_postscale_ff;
  logic [1:0] input_prescale_ff;
  logic [1:0] count_mode_ff;
  logic count_direction_ff;
  logic [14:0] count_value_ff;
  logic [14:0] period_value_ff;
  logic event_direction_ff;
  logic [14:0] event_compare_value_ff;
  logic pair_mode_ff;
  logic high_pin_enable_ff;
  logic low_pin_enable_ff;
  logic [3:0] event_postscale_ff;
  logic [2:0] con2_low_ff;
  logic [15:0] dt1_ff;
  logic [1:0] dt2_ff;
  logic [15:0] duty_ff;
  logic [`MPT_IRQ_WIDTH-1:0] irq_stat_ff;
  logic [`MPT_IRQ_WIDTH-1:0] irq_mask_ff;
  logic cfg_meta_ff;
  logic cfg_sync_ff;
  logic idle_meta_ff;
  logic idle_sync_ff;
  logic [1:0] pen_wait_ff;

  // ----------------------------------------
  // Bus pipeline
  // ----------------------------------------
  logic wr_pend_ff;
  logic [7:0] addr_ff;
  logic [31:0] nxt_rdata;
  logic [3:0] opost_cnt_ff;
  logic [3:0] epost_cnt_ff;
  logic period_hit;
  logic event_hit;
  logic tb_tick;
  logic tb_run;
  logic raw_h;
  logic dt_h;
  logic dt_l;
  logic take;
  logic [7:0] rd_addr;
  logic [14:0] hi_bits;
  logic hit_top;
  logic hit_zero;

  assign take = HSEL && HREADY && HTRANS[1];
  assign rd_addr = HADDR[7:0];

  // Address phase capture
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      wr_pend_ff <= 1'b0;
      addr_ff <= 8'h00;
    end else begin
      wr_pend_ff <= take && HWRITE;
      if (take) begin
        addr_ff <= HADDR[7:0];
      end
    end
  end

  // Zero wait states, always OKAY
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
  end

  // Synchronisers for idle and configuration inputs
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      idle_meta_ff <= 1'b0;
      idle_sync_ff <= 1'b0;
      cfg_meta_ff <= 1'b0;
      cfg_sync_ff <= 1'b0;
    end else begin
      idle_meta_ff <= CPU_IDLE;
      idle_sync_ff <= idle_meta_ff;
      cfg_meta_ff <= PIN_ENABLE_RESET_CONFIG;
      cfg_sync_ff <= cfg_meta_ff;
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      time_base_on_ff <= 1'b0;
      time_base_idle_stop_ff <= 1'b0;
      period_postscale_ff <= 4'h0;
      input_prescale_ff <= 2'h0;
      count_mode_ff <= 2'h0;
      period_value_ff <= 15'h0000;
      event_direction_ff <= 1'b0;
      event_compare_value_ff <= 15'h0000;
      event_postscale_ff <= 4'h0;
      con2_low_ff <= 3'h0;
      dt1_ff <= `MPT_RST_HALF;
      dt2_ff <= 2'h0;
      duty_ff <= `MPT_RST_HALF;
      irq_mask_ff <= `MPT_RST_MASK;
    end else if (wr_pend_ff) begin
      if (addr_ff == `MPT_OFS_TCON) begin
        time_base_on_ff <= HWDATA[`MPT_TCON_ON];
        time_base_idle_stop_ff <= HWDATA[`MPT_TCON_SIDL];
        period_postscale_ff <= HWDATA[`MPT_TCON_OPS_LO +: 4];
        input_prescale_ff <= HWDATA[`MPT_TCON_CKPS_LO +: 2];
        count_mode_ff <= HWDATA[`MPT_TCON_MOD_LO +: 2];
      end else if (addr_ff == `MPT_OFS_TPER) begin
        period_value_ff <= HWDATA[14:0];
      end else if (addr_ff == `MPT_OFS_SECMP) begin
        event_direction_ff <= HWDATA[`MPT_SECMP_DIR];
        event_compare_value_ff <= HWDATA[14:0];
      end else if (addr_ff == `MPT_OFS_CON2) begin
        event_postscale_ff <= HWDATA[`MPT_CON2_SEVOPS_LO +: 4];
        con2_low_ff <= HWDATA[2:0];
      end else if (addr_ff == `MPT_OFS_DTCON1) begin
        dt1_ff <= HWDATA[15:0];
      end else if (addr_ff == `MPT_OFS_DTCON2) begin
        dt2_ff <= HWDATA[1:0];
      end else if (addr_ff == `MPT_OFS_DUTY) begin
        duty_ff <= HWDATA[15:0];
      end else if (addr_ff == `MPT_OFS_IRQ_MASK) begin
        irq_mask_ff <= HWDATA[`MPT_IRQ_WIDTH-1:0];
      end
    end
  end

  // Pair control; pin enables follow the configuration input until its synchroniser settles
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      pair_mode_ff <= 1'b0;
      high_pin_enable_ff <= 1'b0;
      low_pin_enable_ff <= 1'b0;
      pen_wait_ff <= 2'h0;
    end else if (pen_wait_ff != `MPT_PEN_SETTLE) begin
      pen_wait_ff <= pen_wait_ff + 2'h1;
      high_pin_enable_ff <= cfg_sync_ff;
      low_pin_enable_ff <= cfg_sync_ff;
    end else if (wr_pend_ff && addr_ff == `MPT_OFS_CON1) begin
      pair_mode_ff <= HWDATA[`MPT_CON1_PAIR_MODE];
      high_pin_enable_ff <= HWDATA[`MPT_CON1_PENH];
      low_pin_enable_ff <= HWDATA[`MPT_CON1_PENL];
    end
  end

  // ----------------------------------------
  // Time base
  // ----------------------------------------
  // Runs while on and not stopped by idle
  assign tb_run = time_base_on_ff && !(time_base_idle_stop_ff && idle_sync_ff);

  mpt_prescaler u_in_ps (
    .clk(SYS_CLK),
    .rst_n(RESETN),
    .run(tb_run),
    .sel(input_prescale_ff),
    .width_sel(3'h0),
    .tick(tb_tick)
  );

  assign hi_bits = period_value_ff;
  assign hit_top = (count_value_ff >= hi_bits);
  assign hit_zero = (count_value_ff == 15'h0000);

  // Counter in four modes; software writes win
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      count_value_ff <= 15'h0000;
      count_direction_ff <= 1'b0;
    end else if (wr_pend_ff && addr_ff == `MPT_OFS_TMR) begin
      count_value_ff <= HWDATA[14:0];
    end else if (wr_pend_ff && addr_ff == `MPT_OFS_TCON && !HWDATA[`MPT_TCON_ON]) begin
      count_direction_ff <= 1'b0;
    end else if (tb_tick) begin
      case (mpt_mode_type'(count_mode_ff))
        MPT_FREE_RUN: begin
          count_direction_ff <= 1'b0;
          count_value_ff <= hit_top ? 15'h0000 : count_value_ff + 15'h0001;
        end
        MPT_SINGLE: begin
          count_direction_ff <= 1'b0;
          count_value_ff <= hit_top ? 15'h0000 : count_value_ff + 15'h0001;
        end
        default: begin
          if (!count_direction_ff) begin
            if (hit_top) begin
              count_direction_ff <= 1'b1;
              count_value_ff <= count_value_ff - 15'h0001;
            end else begin
              count_value_ff <= count_value_ff + 15'h0001;
            end
          end else if (hit_zero || count_value_ff == 15'h0001) begin
            count_direction_ff <= 1'b0;
            count_value_ff <= hit_zero ? 15'h0001 : 15'h0000;
          end else begin
            count_value_ff <= count_value_ff - 15'h0001;
          end
        end
      endcase
    end
  end

  // Period event per mode; double-update mode also fires at top
  always_comb begin
    period_hit = 1'b0;
    if (tb_tick) begin
      if (count_mode_ff[1]) begin
        period_hit = (count_direction_ff && count_value_ff == 15'h0001) ||
          (count_mode_ff[0] && !count_direction_ff && hit_top);
      end else begin
        period_hit = hit_top;
      end
    end
  end

  // Postscalers for period and special event
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      opost_cnt_ff <= 4'h0;
      epost_cnt_ff <= 4'h0;
    end else begin
      if (period_hit) begin
        opost_cnt_ff <= (opost_cnt_ff >= period_postscale_ff) ? 4'h0 : opost_cnt_ff + 4'h1;
      end
      if (event_hit) begin
        epost_cnt_ff <= (epost_cnt_ff >= event_postscale_ff) ? 4'h0 : epost_cnt_ff + 4'h1;
      end
    end
  end

  // Compare on value and direction
  assign event_hit = tb_tick && (count_value_ff == event_compare_value_ff) &&
    (event_direction_ff == count_direction_ff);

  // ----------------------------------------
  // Interrupts and trigger
  // ----------------------------------------
  // Sticky status, set wins over write-one clear
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      irq_stat_ff <= `MPT_RST_MASK;
      SPECIAL_EVENT <= 1'b0;
    end else begin
      SPECIAL_EVENT <= event_hit && (epost_cnt_ff >= event_postscale_ff);
      irq_stat_ff[`MPT_IRQ_PERIOD] <= (period_hit &&
        (opost_cnt_ff >= period_postscale_ff)) ||
        (irq_stat_ff[`MPT_IRQ_PERIOD] && !(wr_pend_ff && addr_ff == `MPT_OFS_IRQ_STAT &&
        HWDATA[`MPT_IRQ_PERIOD]));
      irq_stat_ff[`MPT_IRQ_SEVT] <= (event_hit && (epost_cnt_ff >= event_postscale_ff)) ||
        (irq_stat_ff[`MPT_IRQ_SEVT] && !(wr_pend_ff && addr_ff == `MPT_OFS_IRQ_STAT &&
        HWDATA[`MPT_IRQ_SEVT]));
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  // ----------------------------------------
  // Output pair
  // ----------------------------------------
  // Duty compare against count: edge-aligned in free-run and single modes, centre-aligned in both up-down modes
  assign raw_h = time_base_on_ff && ({1'b0, count_value_ff} < duty_ff);

  mpt_dead_time u_dt (
    .clk(SYS_CLK),
    .rst_n(RESETN),
    .cnt_a(dt1_ff[`MPT_DT_A_LO +: 6]),
    .ps_a(dt1_ff[`MPT_DT_APS_LO +: 2]),
    .cnt_b(dt1_ff[`MPT_DT_B_LO +: 6]),
    .ps_b(dt1_ff[`MPT_DT_BPS_LO +: 2]),
    .sel_act(dt2_ff[`MPT_DTS_A]),
    .sel_inact(dt2_ff[`MPT_DTS_I]),
    .raw_h(raw_h),
    .out_h(dt_h),
    .out_l(dt_l)
  );

  // Independent or complementary drive, enables hand pins back
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      PWM_H <= 1'b0;
      PWM_L <= 1'b0;
      PWM_H_OE <= 1'b0;
      PWM_L_OE <= 1'b0;
    end else begin
      PWM_H <= pair_mode_ff ? raw_h : dt_h;
      PWM_L <= pair_mode_ff ? raw_h : dt_l;
      PWM_H_OE <= high_pin_enable_ff;
      PWM_L_OE <= low_pin_enable_ff;
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  // Decoded from the address phase so data stand through the data phase
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (rd_addr == `MPT_OFS_TCON) begin
      nxt_rdata[`MPT_TCON_ON] = time_base_on_ff;
      nxt_rdata[`MPT_TCON_SIDL] = time_base_idle_stop_ff;
      nxt_rdata[`MPT_TCON_OPS_LO +: 4] = period_postscale_ff;
      nxt_rdata[`MPT_TCON_CKPS_LO +: 2] = input_prescale_ff;
      nxt_rdata[`MPT_TCON_MOD_LO +: 2] = count_mode_ff;
    end else if (rd_addr == `MPT_OFS_TMR) begin
      nxt_rdata[`MPT_TMR_DIR] = count_direction_ff;
      nxt_rdata[14:0] = count_value_ff;
    end else if (rd_addr == `MPT_OFS_TPER) begin
      nxt_rdata[14:0] = period_value_ff;
    end else if (rd_addr == `MPT_OFS_SECMP) begin
      nxt_rdata[`MPT_SECMP_DIR] = event_direction_ff;
      nxt_rdata[14:0] = event_compare_value_ff;
    end else if (rd_addr == `MPT_OFS_CON1) begin
      nxt_rdata[`MPT_CON1_PAIR_MODE] = pair_mode_ff;
      nxt_rdata[`MPT_CON1_PENH] = high_pin_enable_ff;
      nxt_rdata[`MPT_CON1_PENL] = low_pin_enable_ff;
    end else if (rd_addr == `MPT_OFS_CON2) begin
      nxt_rdata[`MPT_CON2_SEVOPS_LO +: 4] = event_postscale_ff;
      nxt_rdata[2:0] = con2_low_ff;
    end else if (rd_addr == `MPT_OFS_DTCON1) begin
      nxt_rdata[15:0] = dt1_ff;
    end else if (rd_addr == `MPT_OFS_DTCON2) begin
      nxt_rdata[1:0] = dt2_ff;
    end else if (rd_addr == `MPT_OFS_DUTY) begin
      nxt_rdata[15:0] = duty_ff;
    end else if (rd_addr == `MPT_OFS_IRQ_STAT) begin
      nxt_rdata[`MPT_IRQ_WIDTH-1:0] = irq_stat_ff;
    end else if (rd_addr == `MPT_OFS_IRQ_MASK) begin
      nxt_rdata[`MPT_IRQ_WIDTH-1:0] = irq_mask_ff;
    end
  end

  // Read data registered at the address phase, unmapped reads zero
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      HRDATA <= 32'h0000_0000;
    end else if (take && !HWRITE) begin
      HRDATA <= nxt_rdata;
    end
  end
endmodule

// File: verification/mpt_core_sva.sv
// Port checker for the PWM time base core
`timescale 1ns/1ps
`include "mpt_defs.svh"
module mpt_core_sva
  import mpt_pkg::*;
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESETN,
  // Bus
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  // Events
  input wire logic SPECIAL_EVENT,
  input wire logic IRQ
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESETN);
  logic rd_ff;
  logic wr_ff;
  logic [7:0] adr_ff;
  // Address phase taken at the previous edge
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rd_ff <= 1'b0;
      wr_ff <= 1'b0;
      adr_ff <= 8'h00;
    end else begin
      rd_ff <= HSEL && HREADY && HTRANS[1] && !HWRITE;
      wr_ff <= HSEL && HREADY && HTRANS[1] && HWRITE;
      adr_ff <= HADDR[7:0];
    end
  end
  property p_bus_ok;
    HREADYOUT && !HRESP;
  endproperty
  a_bus_ok: assert property (p_bus_ok) else $error("bus answer not ready or not okay");
  property p_upper_zero;
    rd_ff |-> HRDATA[31:16] == 16'h0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read half set");
  property p_unmapped;
    rd_ff && adr_ff == 8'h2C |-> HRDATA == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_period_top;
    rd_ff && adr_ff == `MPT_OFS_TPER |-> !HRDATA[15];
  endproperty
  a_period_top: assert property (p_period_top) else $error("period top bit set");
  property p_pair_only;
    rd_ff && adr_ff == `MPT_OFS_CON1 |-> HRDATA[10:9] == 2'h0 && HRDATA[6:5] == 2'h0
      && HRDATA[2:1] == 2'h0;
  endproperty
  a_pair_only: assert property (p_pair_only) else $error("absent pair bits set");
  property p_rdata_hold;
    !rd_ff |-> $stable(HRDATA);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read");
  property p_event_pulse;
    SPECIAL_EVENT |=> !SPECIAL_EVENT;
  endproperty
  a_event_pulse: assert property (p_event_pulse) else $error("event pulse too long");
  property p_mask_off;
    wr_ff && adr_ff == `MPT_OFS_IRQ_MASK && HWDATA[1:0] == 2'h0 |-> ##2 !IRQ;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("interrupt high while all masked");
  // Main scenarios reached
  c_irq: cover property ($rose(IRQ));
  c_event: cover property (SPECIAL_EVENT);
  c_unmapped: cover property (rd_ff && adr_ff == 8'h2C);
endmodule
bind mpt_core mpt_core_sva i_mpt_core_sva (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .HSEL(HSEL),
  .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY),
  .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SPECIAL_EVENT(SPECIAL_EVENT),
  .IRQ(IRQ));

// File: verification/mpt_gate_drv.sv
// Gate driver stand-in that counts on-time and overlap of the pair
`timescale 1ns/1ps
module mpt_gate_drv (
  // Clock and window clear
  input wire logic clk,
  input wire logic clr,
  // Pair from the core
  input wire logic drv_h,
  input wire logic drv_l,
  input wire logic oe_h,
  input wire logic oe_l,
  // Observed counts
  output int hi_cnt,
  output int lo_cnt,
  output int lap_cnt
);
  logic gate_h;
  logic gate_l;
  // Released pins fall to the gate pull-down
  assign gate_h = oe_h ? drv_h : 1'b0;
  assign gate_l = oe_l ? drv_l : 1'b0;
  // On-time and shoot-through counters
  always @(posedge clk) begin
    hi_cnt <= clr ? 0 : hi_cnt + int'(gate_h === 1'b1);
    lo_cnt <= clr ? 0 : lo_cnt + int'(gate_l === 1'b1);
    lap_cnt <= clr ? 0 : lap_cnt + int'(gate_h === 1'b1 && gate_l === 1'b1);
  end
endmodule

// File: verification/test_motor_pwm_time_base_core.sv
// Self-checking bench for the PWM time base core
`timescale 1ns/1ps
`include "mpt_defs.svh"
module test_motor_pwm_time_base_core
  import mpt_pkg::*;
;
  logic SYS_CLK, RESETN, HSEL, HWRITE, CPU_IDLE, CFG, clr;
  logic [31:0] HADDR, HWDATA, HRDATA, rd;
  logic [1:0] HTRANS, dirs;
  logic [2:0] HSIZE;
  logic HREADYOUT, HRESP, PWM_H, PWM_L, PWM_H_OE, PWM_L_OE, SPECIAL_EVENT, IRQ;
  int n_errors = 0, checks = 0, cyc = 0, ev_cnt = 0, hi_cnt, lo_cnt, lap_cnt, n, t1, t2;
  int div[4] = '{1, 4, 16, 64};
  int ops[3] = '{0, 1, 15};
  mpt_core i_mpt_core (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .CPU_IDLE(CPU_IDLE),
    .PIN_ENABLE_RESET_CONFIG(CFG), .PWM_H(PWM_H), .PWM_L(PWM_L), .PWM_H_OE(PWM_H_OE),
    .PWM_L_OE(PWM_L_OE), .SPECIAL_EVENT(SPECIAL_EVENT), .IRQ(IRQ));
  mpt_gate_drv i_mpt_gate_drv (.clk(SYS_CLK), .clr(clr), .drv_h(PWM_H), .drv_l(PWM_L),
    .oe_h(PWM_H_OE), .oe_l(PWM_L_OE), .hi_cnt(hi_cnt), .lo_cnt(lo_cnt), .lap_cnt(lap_cnt));
  // Clock
  initial begin
    SYS_CLK = 1'b0;
    forever #4 SYS_CLK = ~SYS_CLK;
  end
  // Cycle and event counters
  always @(posedge SYS_CLK) begin
    cyc <= cyc + 1;
    ev_cnt <= clr ? 0 : ev_cnt + int'(SPECIAL_EVENT === 1'b1);
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One single AHB-Lite word transfer
  task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] d);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= {24'h0, a};
    HWRITE <= wr;
    @(posedge SYS_CLK);
    while (HREADYOUT !== 1'b1) @(posedge SYS_CLK);
    HTRANS <= 2'h0;
    HSEL <= 1'b0;
    HWDATA <= wr ? d : 32'h0;
    @(posedge SYS_CLK);
    while (HREADYOUT !== 1'b1) @(posedge SYS_CLK);
    rd = HRDATA;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    check(rd, exp);
  endtask
  // Count reached over 1024 cycles of running
  task automatic span(input logic [15:0] tcon, output int c);
    xfer(`MPT_OFS_TMR, 1'b1, 32'h0);
    xfer(`MPT_OFS_TCON, 1'b1, {16'h0, tcon});
    repeat (1022) @(posedge SYS_CLK);
    xfer(`MPT_OFS_TCON, 1'b1, 32'h0);
    xfer(`MPT_OFS_TMR, 1'b0, 32'h0);
    c = int'(rd[14:0]);
  endtask
  function automatic logic near(int c, int e);
    return (c >= e - 2) && (c <= e + 2);
  endfunction
  // Next interrupt rise, then clear it
  task automatic rise(output int t);
    while (IRQ !== 1'b0) @(posedge SYS_CLK);
    while (IRQ !== 1'b1) @(posedge SYS_CLK);
    t = cyc;
    xfer(`MPT_OFS_IRQ_STAT, 1'b1, 32'h1);
  endtask
  // Window of 100 cycles for event and pin counts
  task automatic win(output int c);
    repeat (4) @(posedge SYS_CLK);
    clr <= 1'b1;
    @(posedge SYS_CLK);
    clr <= 1'b0;
    repeat (101) @(posedge SYS_CLK);
    c = ev_cnt;
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (30000) @(posedge SYS_CLK);
    n_errors++;
    report_and_stop;
  end
  // Main sequence
  initial begin
    RESETN = 1'b0;
    HSEL = 1'b0;
    HTRANS = 2'h0;
    HADDR = 32'h0;
    HWRITE = 1'b0;
    HSIZE = 3'h2;
    HWDATA = 32'h0;
    CPU_IDLE = 1'b0;
    CFG = 1'b1;
    clr = 1'b0;
    repeat (6) @(posedge SYS_CLK);
    RESETN <= 1'b1;
    repeat (4) @(posedge SYS_CLK);
    rdchk(`MPT_OFS_TCON, 32'h0);
    rdchk(`MPT_OFS_CON1, 32'h11);
    xfer(8'h2C, 1'b1, 32'h1234);
    rdchk(8'h2C, 32'h0);
    xfer(`MPT_OFS_TPER, 1'b1, 32'hFFFF_FFFF);
    rdchk(`MPT_OFS_TPER, 32'h7FFF);
    xfer(`MPT_OFS_TMR, 1'b1, 32'hFFFF);
    rdchk(`MPT_OFS_TMR, 32'h7FFF);
    xfer(`MPT_OFS_DTCON1, 1'b1, 32'hFFFF);
    rdchk(`MPT_OFS_DTCON1, 32'hFFFF);
    xfer(`MPT_OFS_DTCON1, 1'b1, 32'h0);
    for (int m = 0; m < 4; m++) begin
      xfer(`MPT_OFS_TCON, 1'b1, 32'(mpt_mode_type'(m)));
      rdchk(`MPT_OFS_TCON, 32'(m));
    end
    $display("registers done");
    foreach (div[i]) begin
      span(16'h8000 | 16'(i << 2), n);
      check(32'(near(n, 1024 / div[i])), 32'h1);
    end
    span(16'h0000, n);
    check(32'(n), 32'h0);
    CPU_IDLE <= 1'b1;
    span(16'hA000, n);
    check(32'(near(n, 0)), 32'h1);
    span(16'h8000, n);
    check(32'(near(n, 1024)), 32'h1);
    CPU_IDLE <= 1'b0;
    $display("time base done");
    xfer(`MPT_OFS_TPER, 1'b1, 32'd9);
    xfer(`MPT_OFS_IRQ_MASK, 1'b1, 32'h1);
    foreach (ops[i]) begin
      xfer(`MPT_OFS_TCON, 1'b1, 32'h8000 | 32'(ops[i] << 4));
      xfer(`MPT_OFS_IRQ_STAT, 1'b1, 32'h1);
      rise(t1);
      rise(t2);
      check(32'(t2 - t1), 32'((ops[i] + 1) * 10));
    end
    xfer(`MPT_OFS_IRQ_MASK, 1'b1, 32'h0);
    // Long enough for one 1:16 postscaled period event while masked
    repeat (170) @(posedge SYS_CLK);
    xfer(`MPT_OFS_TCON, 1'b1, 32'h0);
    check({31'h0, IRQ}, 32'h0);
    rdchk(`MPT_OFS_IRQ_STAT, 32'h3);
    xfer(`MPT_OFS_IRQ_STAT, 1'b1, 32'h3);
    rdchk(`MPT_OFS_IRQ_STAT, 32'h0);
    $display("interrupts done");
    xfer(`MPT_OFS_SECMP, 1'b1, 32'h0005);
    xfer(`MPT_OFS_TCON, 1'b1, 32'h8000);
    win(n);
    check(32'(n), 32'd10);
    xfer(`MPT_OFS_CON2, 1'b1, 32'h0100);
    win(n);
    check(32'(n), 32'd5);
    xfer(`MPT_OFS_CON2, 1'b1, 32'h0);
    xfer(`MPT_OFS_SECMP, 1'b1, 32'h8005);
    win(n);
    check(32'(n), 32'd0);
    xfer(`MPT_OFS_TCON, 1'b1, 32'h8002);
    win(n);
    check(32'(n != 0), 32'h1);
    dirs = 2'b00;
    repeat (12) begin
      xfer(`MPT_OFS_TMR, 1'b0, 32'h0);
      dirs = dirs | (2'b01 << rd[15]);
    end
    check(32'(dirs), 32'h3);
    $display("special event done");
    xfer(`MPT_OFS_TCON, 1'b1, 32'h8000);
    xfer(`MPT_OFS_DUTY, 1'b1, 32'd5);
    win(n);
    check(32'(hi_cnt), 32'd50);
    check(32'(lo_cnt), 32'd50);
    check(32'(lap_cnt), 32'd0);
    xfer(`MPT_OFS_CON1, 1'b1, 32'h111);
    rdchk(`MPT_OFS_CON1, 32'h111);
    xfer(`MPT_OFS_CON1, 1'b1, 32'h01);
    win(n);
    check(32'(hi_cnt), 32'd0);
    check({31'h0, PWM_L_OE}, 32'h1);
    xfer(`MPT_OFS_CON1, 1'b1, 32'h11);
    xfer(`MPT_OFS_DTCON1, 1'b1, 32'h0003);
    win(n);
    check(32'(hi_cnt < 50), 32'h1);
    check(32'(lap_cnt), 32'd0);
    $display("outputs done");
    CFG <= 1'b0;
    RESETN <= 1'b0;
    repeat (2) @(posedge SYS_CLK);
    RESETN <= 1'b1;
    repeat (4) @(posedge SYS_CLK);
    rdchk(`MPT_OFS_CON1, 32'h0);
    check({31'h0, PWM_H_OE}, 32'h0);
    $display("reset config done");
    report_and_stop;
  end
endmodule
